// ### test/skcx_exec_sva.sv
`timescale 1ns/1ns
module skcx_exec_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire skcx_pkg::skcx_req_t req,
    input wire logic req_ready,
    input wire skcx_pkg::skcx_rsp_t rsp,
    input wire logic [skcx_pkg::IRF_NUM-1:0] irf_clr,
    input wire logic skip_pending_flag,
    input wire logic group_a_seq_flag,
    input wire logic group_b_seq_flag,
    input wire logic maskable_int_ok,
    input wire logic nmi_int_ok,
    input wire logic halt_mode,
    input wire logic stop_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    wire logic taken = req.valid && req_ready;
    // A pending skip passes the instruction, so mode and enable effects need a live take
    wire logic live = taken && !skip_pending_flag;
    sequence nop_take;
        taken && req.op0 == skcx_pkg::OP_NOP;
    endsequence
    sequence skip_take;
        taken && req.op0 == skcx_pkg::OP_PREFIX && (req.op1[7:3] == 5'b00011 || req.op1[7:6] == 2'b01);
    endsequence
    sequence pwr_take(logic [7:0] code);
        live && req.op0 == skcx_pkg::OP_PREFIX && req.op1 == code;
    endsequence
    a_nmi_never_cleared: assert property (!irf_clr[0]) else $error("nmi flag cleared");
    a_clear_one_pulse: assert property ((|irf_clr) |-> $past(taken) ##1 !(|irf_clr))
        else $error("request clear pulse misplaced");
    a_nop_four_states: assert property (nop_take |=> !rsp.done [*8] ##5 rsp.done)
        else $error("nop length wrong");
    a_nop_clears_flags: assert property (nop_take |=> !(skip_pending_flag || group_a_seq_flag))
        else $error("nop left flags set");
    a_skip_eight_states: assert property (skip_take |-> ##25 rsp.done)
        else $error("skip length wrong");
    a_skip_clears_seq: assert property (skip_take |=> !(group_a_seq_flag || group_b_seq_flag))
        else $error("skip left sequence flag");
    a_di_blocks_now: assert property (live && req.op0 == skcx_pkg::OP_DI |=> !maskable_int_ok)
        else $error("disable late");
    a_halt_entry: assert property (pwr_take(skcx_pkg::OP2_HALT) |-> ##37 rsp.done ##[1:2] halt_mode)
        else $error("halt entry wrong");
    a_stop_entry: assert property (pwr_take(skcx_pkg::OP2_STOP) |-> ##37 rsp.done ##[1:2] stop_mode)
        else $error("stop entry wrong");
    a_nmi_ok_holds: assert property (nmi_int_ok |=> nmi_int_ok)
        else $error("nmi acceptance dropped");
    a_mode_refuses: assert property (halt_mode || stop_mode |-> !req_ready)
        else $error("request taken in power mode");
endmodule : skcx_exec_sva

// ### test/skcx_exec_tb.sv
`timescale 1ns/1ns
module skcx_exec_tb;
    logic clk, rstn, carry_flag, half_carry_flag, zero_flag, int_entry, reti_valid, wake, err;
    logic psel, penable, pwrite, pready, pslverr, req_ready, skip_pending_flag, group_a_seq_flag;
    logic group_b_seq_flag, maskable_int_ok, nmi_int_ok, halt_mode, stop_mode;
    logic [7:0] reti_status_byte, status_byte;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [20:0] irf_flags, irf_clr, clr;
    logic [4:0] codes [3] = '{5'h05, 5'h14, 5'h00};
    skcx_pkg::skcx_req_t req;
    skcx_pkg::skcx_rsp_t rsp, r;
    int mismatches, comparisons;

    skcx_exec u_skcx_exec (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Counts edges from the taking edge to the edge that launches the done pulse
    task automatic run(input logic [7:0] o0, input logic [7:0] o1, input logic la, input logic lb, input int exp);
        int n;
        n = 0;
        clr = '0;
        @(posedge clk);
        req <= '{1'b1, o0, o1, skcx_pkg::LEN_2, 5'd7, la, lb, 1'b0};
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        req.valid <= 1'b0;
        // Done launches at edge 3*states after taking; it is seen one edge later
        n = -1;
        do begin
            @(posedge clk);
            n++;
            clr |= irf_clr;
        end while (rsp.done !== 1'b1 && n < 200);
        r = rsp;
        chk(n, exp);
    endtask : run

    task automatic test_done;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // Whole run is little more than a thousand cycles; this leaves a wide margin
    initial begin
        #400000;
        mismatches++;
        test_done();
    end

    initial begin
        {rstn, carry_flag, half_carry_flag, zero_flag, int_entry, reti_valid, wake} = '0;
        {psel, penable, pwrite, paddr, pwdata, reti_status_byte, irf_flags} = '0;
        req = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, skcx_pkg::REG_CTRL, 32'h0000_0000);
        chk(rd, skcx_pkg::CTRL_RESET);
        chk(err, 1'b0);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk({rd, err}, 32'h0000_0001);
        $display("test registers done");
        for (int f = 2; f <= 4; f++) begin
            for (int v = 0; v < 2; v++) begin
                {zero_flag, half_carry_flag, carry_flag} <= v[0] ? 3'b111 : ~(3'b001 << (f - 2));
                run(8'h69, 8'h00, 1'b1, 1'b0, 21);
                run(skcx_pkg::OP_PREFIX, {2'b00, skcx_pkg::OP2_SKN_HI, f[2:0]}, 1'b0, 1'b0, 24);
                chk(r.pc_adv, skcx_pkg::LEN_2);
                chk(skip_pending_flag, !v[0]);
                chk(group_a_seq_flag, 1'b0);
                run(skcx_pkg::OP_NOP, 8'h00, 1'b0, 1'b0, 12);
                chk({r.skipped, r.pc_adv}, {!v[0], skcx_pkg::LEN_1});
                chk(skip_pending_flag, 1'b0);
            end
        end
        $display("test flag skips done");
        foreach (codes[i]) begin
            for (int k = 0; k < 4; k++) begin
                irf_flags <= {20'h0, k[0]} << codes[i];
                run(skcx_pkg::OP_PREFIX, {k[1] ? skcx_pkg::OP2_SKIP_IF_REQUEST_CLEAR_HI : skcx_pkg::OP2_SKIP_IF_REQUEST_SET_HI, codes[i]},
                    1'b0, 1'b0, 24);
                chk(skip_pending_flag, k[0] ^ k[1]);
                chk(clr, {20'h0, k[0] && codes[i] != 5'h00} << codes[i]);
                run(skcx_pkg::OP_NOP, 8'h00, 1'b0, 1'b0, 12);
            end
        end
        irf_flags <= '0;
        $display("test request skips done");
        for (int j = 0; j < 5; j++) begin
            run(8'h6A, 8'h00, j < 3, j >= 3, 21);
            chk(r.suppressed, j != 0 && j != 3);
            chk(j < 3 ? group_a_seq_flag : group_b_seq_flag, 1'b1);
        end
        int_entry <= 1'b1;
        @(posedge clk);
        int_entry <= 1'b0;
        @(posedge clk);
        chk(status_byte[skcx_pkg::PSW_L0], 1'b1);
        reti_status_byte <= 8'h08;
        reti_valid <= 1'b1;
        @(posedge clk);
        reti_valid <= 1'b0;
        @(posedge clk);
        chk({skip_pending_flag, group_a_seq_flag, group_b_seq_flag}, 3'b010);
        run(8'h6A, 8'h00, 1'b1, 1'b0, 21);
        chk(r.suppressed, 1'b1);
        $display("test stacking done");
        run(skcx_pkg::OP_EI, 8'h00, 1'b0, 1'b0, 12);
        chk(maskable_int_ok, 1'b0);
        run(skcx_pkg::OP_NOP, 8'h00, 1'b0, 1'b0, 12);
        chk(maskable_int_ok, 1'b0);
        repeat (3) @(posedge clk);
        chk(maskable_int_ok, 1'b1);
        run(skcx_pkg::OP_DI, 8'h00, 1'b0, 1'b0, 12);
        chk({maskable_int_ok, nmi_int_ok}, 2'b01);
        $display("test enable done");
        for (int m = 0; m < 2; m++) begin
            run(skcx_pkg::OP_PREFIX, m ? skcx_pkg::OP2_STOP : skcx_pkg::OP2_HALT, 1'b0, 1'b0, 36);
            chk(r.pc_adv, skcx_pkg::LEN_2);
            repeat (3) @(posedge clk);
            chk({stop_mode, halt_mode, req_ready}, m ? 3'b100 : 3'b010);
            apb(1'b1, skcx_pkg::REG_CTRL, 32'h0000_0003);
            repeat (3) @(posedge clk);
            chk({stop_mode, halt_mode}, 2'b00);
        end
        $display("test power modes done");
        test_done();
    end
endmodule : skcx_exec_tb

bind skcx_exec skcx_exec_sva u_skcx_exec_sva (.*);

// ### verilog/skcx_exec.sv
`timescale 1ns/1ns
module skcx_exec (
    input wire logic clk,
    input wire logic rstn,
    input wire skcx_pkg::skcx_req_t req,
    input wire logic carry_flag,
    input wire logic half_carry_flag,
    input wire logic zero_flag,
    input wire logic [skcx_pkg::IRF_NUM-1:0] irf_flags,
    input wire logic int_entry,
    input wire logic reti_valid,
    input wire logic [7:0] reti_status_byte,
    input wire logic wake,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic req_ready,
    output skcx_pkg::skcx_rsp_t rsp,
    output logic [skcx_pkg::IRF_NUM-1:0] irf_clr,
    output logic [7:0] status_byte,
    output logic skip_pending_flag,
    output logic group_a_seq_flag,
    output logic group_b_seq_flag,
    output logic maskable_int_ok,
    output logic nmi_int_ok,
    output logic halt_mode,
    output logic stop_mode
);
    typedef enum logic [1:0] {
        SKCX_S_IDLE = 2'b01,
        SKCX_S_RUN = 2'b10
    } skcx_state_t;

    function automatic skcx_pkg::skcx_dec_t skcx_decode(input skcx_pkg::skcx_req_t r);
        skcx_pkg::skcx_dec_t d;
        d.kind = skcx_pkg::SKCX_K_OTHER;
        d.len = r.len;
        d.states = r.states;
        if (r.op0 == skcx_pkg::OP_NOP || r.op0 == skcx_pkg::OP_EI || r.op0 == skcx_pkg::OP_DI) begin
            d.kind = skcx_pkg::SKCX_K_CTRL;
            d.len = skcx_pkg::LEN_1;
            d.states = skcx_pkg::ST_CTRL;
        end else if (r.op0 == skcx_pkg::OP_PREFIX) begin
            if (r.op1 == skcx_pkg::OP2_HALT || r.op1 == skcx_pkg::OP2_STOP) begin
                d.kind = skcx_pkg::SKCX_K_PWR;
                d.len = skcx_pkg::LEN_2;
                d.states = skcx_pkg::ST_PWR;
            end else if (r.op1[7:3] == {2'b00, skcx_pkg::OP2_SKN_HI} ||
                         r.op1[7:5] == skcx_pkg::OP2_SKIP_IF_REQUEST_SET_HI ||
                         r.op1[7:5] == skcx_pkg::OP2_SKIP_IF_REQUEST_CLEAR_HI) begin
                d.kind = skcx_pkg::SKCX_K_SKIP;
                d.len = skcx_pkg::LEN_2;
                d.states = skcx_pkg::ST_SKIP;
            end
        end
        return d;
    endfunction : skcx_decode

    function automatic logic irf_code_ok(input logic [4:0] c);
        return (c <= skcx_pkg::IRF_LO_MAX) || (c >= skcx_pkg::IRF_HI_MIN && c <= skcx_pkg::IRF_HI_MAX);
    endfunction : irf_code_ok

    skcx_state_t state_r;
    logic [4:0] states_left_r;
    logic [1:0] div_r;
    logic state_tick;
    logic [31:0] ctrl_r;
    logic ie_r;
    logic ie_pend_r;
    logic ie_arm_r;
    logic [1:0] pwr_op_r;
    skcx_pkg::skcx_rsp_t rsp_nxt;
    skcx_pkg::skcx_dec_t dec;
    logic issue;
    logic is_skn;
    logic is_skip_if_request_set;
    logic is_skip_if_request_clear;
    logic [4:0] irf_code;
    logic irf_val;
    logic aflag_val;
    logic test_skip;
    logic suppress;
    logic [skcx_pkg::IRF_NUM-1:0] irf_clr_nxt;

    assign issue = req.valid && req_ready;
    assign dec = skcx_decode(req);
    assign is_skn = dec.kind == skcx_pkg::SKCX_K_SKIP && req.op1[7:5] == 3'b000;
    assign is_skip_if_request_set = dec.kind == skcx_pkg::SKCX_K_SKIP && req.op1[7:5] == skcx_pkg::OP2_SKIP_IF_REQUEST_SET_HI;
    assign is_skip_if_request_clear = dec.kind == skcx_pkg::SKCX_K_SKIP && req.op1[7:5] == skcx_pkg::OP2_SKIP_IF_REQUEST_CLEAR_HI;
    assign irf_code = req.op1[4:0];
    // Codes outside the documented ranges read as a clear flag
    assign irf_val = irf_code_ok(irf_code) && irf_flags[irf_code];
    assign state_tick = div_r == skcx_pkg::CLKS_PER_STATE - 2'd1;
    // A stacked load is idled only when it is not itself being skipped
    assign suppress = ctrl_r[skcx_pkg::CTRL_STACK_EN] && !skip_pending_flag &&
                      ((req.ldi_a && group_a_seq_flag) || (req.ldi_b && group_b_seq_flag));

    always_comb begin
        case (req.op1[2:0])
            skcx_pkg::FSEL_CY: aflag_val = carry_flag;
            skcx_pkg::FSEL_HC: aflag_val = half_carry_flag;
            skcx_pkg::FSEL_Z: aflag_val = zero_flag;
            default: aflag_val = 1'b1;
        endcase
    end

    always_comb begin
        test_skip = 1'b0;
        if (is_skn) begin
            test_skip = !aflag_val;
        end else if (is_skip_if_request_set) begin
            test_skip = irf_val;
        end else if (is_skip_if_request_clear) begin
            test_skip = !irf_val;
        end
    end

    always_comb begin
        irf_clr_nxt = '0;
        if (issue && !skip_pending_flag && (is_skip_if_request_set || is_skip_if_request_clear) && irf_val && irf_code != skcx_pkg::IRF_NMI) begin
            irf_clr_nxt[irf_code] = 1'b1;
        end
    end

    // Clocked state divider; runs only while an instruction executes
    always_ff @(posedge clk) begin
        if (!rstn || state_r != SKCX_S_RUN || state_tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= SKCX_S_IDLE;
            states_left_r <= '0;
            req_ready <= 1'b0;
        end else begin
            case (state_r)
                SKCX_S_IDLE: begin
                    // Stay closed while a halt or stop is about to take hold
                    req_ready <= !(halt_mode || stop_mode ||
                                   (rsp.done && !rsp.skipped && pwr_op_r != 2'b00));
                    if (issue) begin
                        state_r <= SKCX_S_RUN;
                        states_left_r <= dec.states;
                        req_ready <= 1'b0;
                    end
                end
                SKCX_S_RUN: begin
                    if (state_tick) begin
                        states_left_r <= states_left_r - 5'd1;
                        if (states_left_r == 5'd1) begin
                            state_r <= SKCX_S_IDLE;
                        end
                    end
                end
                default: state_r <= SKCX_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rsp_nxt <= '0;
        end else if (issue) begin
            rsp_nxt.done <= 1'b0;
            rsp_nxt.pc_adv <= dec.len;
            rsp_nxt.skipped <= skip_pending_flag;
            rsp_nxt.suppressed <= suppress;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rsp <= '0;
        end else begin
            rsp <= rsp_nxt;
            rsp.done <= state_r == SKCX_S_RUN && state_tick && states_left_r == 5'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irf_clr <= '0;
        end else begin
            irf_clr <= irf_clr_nxt;
        end
    end

    // Skip and sequence flags
    always_ff @(posedge clk) begin
        if (!rstn) begin
            skip_pending_flag <= 1'b0;
            group_a_seq_flag <= 1'b0;
            group_b_seq_flag <= 1'b0;
        end else if (reti_valid) begin
            skip_pending_flag <= reti_status_byte[skcx_pkg::PSW_SK];
            group_a_seq_flag <= reti_status_byte[skcx_pkg::PSW_L1];
            group_b_seq_flag <= reti_status_byte[skcx_pkg::PSW_L0];
        end else if (issue) begin
            if (skip_pending_flag) begin
                skip_pending_flag <= 1'b0;
                group_a_seq_flag <= 1'b0;
                group_b_seq_flag <= 1'b0;
            end else if (dec.kind == skcx_pkg::SKCX_K_SKIP) begin
                skip_pending_flag <= test_skip;
                group_a_seq_flag <= 1'b0;
                group_b_seq_flag <= 1'b0;
            end else if (dec.kind == skcx_pkg::SKCX_K_OTHER) begin
                skip_pending_flag <= req.other_skip && !suppress;
                group_a_seq_flag <= req.ldi_a;
                group_b_seq_flag <= req.ldi_b;
            end else begin
                skip_pending_flag <= 1'b0;
                group_a_seq_flag <= 1'b0;
                group_b_seq_flag <= 1'b0;
            end
        end
    end

    // Snapshot for the stack push; interrupts stay open during stacked runs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            status_byte <= '0;
        end else if (int_entry) begin
            status_byte <= '0;
            status_byte[skcx_pkg::PSW_Z] <= zero_flag;
            status_byte[skcx_pkg::PSW_SK] <= skip_pending_flag;
            status_byte[skcx_pkg::PSW_HC] <= half_carry_flag;
            status_byte[skcx_pkg::PSW_L1] <= group_a_seq_flag;
            status_byte[skcx_pkg::PSW_L0] <= group_b_seq_flag;
            status_byte[skcx_pkg::PSW_CY] <= carry_flag;
        end
    end

    // Interrupt enable; a skipped enable or disable changes nothing
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ie_r <= 1'b0;
            ie_pend_r <= 1'b0;
            ie_arm_r <= 1'b0;
        end else if (issue && !skip_pending_flag && req.op0 == skcx_pkg::OP_DI) begin
            ie_r <= 1'b0;
            ie_pend_r <= 1'b0;
            ie_arm_r <= 1'b0;
        end else if (issue && !skip_pending_flag && req.op0 == skcx_pkg::OP_EI) begin
            ie_pend_r <= 1'b1;
        end else if (issue && ie_pend_r) begin
            // The instruction after the enable must finish first
            ie_pend_r <= 1'b0;
            ie_arm_r <= 1'b1;
        end else if (rsp.done && ie_arm_r) begin
            ie_arm_r <= 1'b0;
            ie_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            maskable_int_ok <= 1'b0;
            nmi_int_ok <= 1'b0;
        end else begin
            // A disable taken in this cycle must close the window at once
            maskable_int_ok <= ie_r && !(issue && !skip_pending_flag && req.op0 == skcx_pkg::OP_DI);
            nmi_int_ok <= 1'b1;
        end
    end

    // Power modes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            halt_mode <= 1'b0;
            stop_mode <= 1'b0;
        end else if (wake || (psel && penable && pwrite && paddr == skcx_pkg::REG_CTRL &&
                     pwdata[skcx_pkg::CTRL_WAKE])) begin
            halt_mode <= 1'b0;
            stop_mode <= 1'b0;
        end else if (rsp.done && !rsp.skipped && rsp_nxt.pc_adv == skcx_pkg::LEN_2 && pwr_op_r != 2'b00) begin
            halt_mode <= pwr_op_r[0];
            stop_mode <= pwr_op_r[1];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pwr_op_r <= 2'b00;
        end else if (issue) begin
            pwr_op_r <= '0;
            if (dec.kind == skcx_pkg::SKCX_K_PWR && !skip_pending_flag) begin
                pwr_op_r <= {req.op1 == skcx_pkg::OP2_STOP, req.op1 == skcx_pkg::OP2_HALT};
            end
        end
    end

    // APB slave, no wait states: answer in the access cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r <= skcx_pkg::CTRL_RESET;
        end else if (psel && penable && pwrite && paddr == skcx_pkg::REG_CTRL) begin
            ctrl_r <= '0;
            ctrl_r[skcx_pkg::CTRL_STACK_EN] <= pwdata[skcx_pkg::CTRL_STACK_EN];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != skcx_pkg::REG_CTRL && paddr != skcx_pkg::REG_STATUS;
            prdata <= '0;
            if (psel && !penable && !pwrite && paddr == skcx_pkg::REG_CTRL) begin
                prdata <= ctrl_r;
            end else if (psel && !penable && !pwrite && paddr == skcx_pkg::REG_STATUS) begin
                prdata <= {24'h00_0000, state_r == SKCX_S_RUN, stop_mode, halt_mode, ie_pend_r, ie_r,
                           group_b_seq_flag, group_a_seq_flag, skip_pending_flag};
            end
        end
    end
endmodule : skcx_exec

// ### verilog/skcx_pkg.sv
package skcx_pkg;
    // Opcode bytes
    localparam logic [7:0] OP_PREFIX = 8'h48;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_EI = 8'hAA;
    localparam logic [7:0] OP_DI = 8'hBA;
    localparam logic [7:0] OP2_HALT = 8'h3B;
    localparam logic [7:0] OP2_STOP = 8'hBB;
    localparam logic [2:0] OP2_SKN_HI = 3'h3;
    localparam logic [2:0] OP2_SKIP_IF_REQUEST_SET_HI = 3'h2;
    localparam logic [2:0] OP2_SKIP_IF_REQUEST_CLEAR_HI = 3'h3;
    // Arithmetic flag select codes
    localparam logic [2:0] FSEL_CY = 3'h2;
    localparam logic [2:0] FSEL_HC = 3'h3;
    localparam logic [2:0] FSEL_Z = 3'h4;
    // Request flag codes
    localparam int IRF_NUM = 21;
    localparam logic [4:0] IRF_NMI = 5'h00;
    localparam logic [4:0] IRF_LO_MAX = 5'h0C;
    localparam logic [4:0] IRF_HI_MIN = 5'h10;
    localparam logic [4:0] IRF_HI_MAX = 5'h14;
    // Lengths and state counts
    localparam logic [1:0] LEN_1 = 2'd1;
    localparam logic [1:0] LEN_2 = 2'd2;
    localparam logic [4:0] ST_CTRL = 5'd4;
    localparam logic [4:0] ST_SKIP = 5'd8;
    localparam logic [4:0] ST_PWR = 5'd12;
    localparam logic [1:0] CLKS_PER_STATE = 2'd3;
    // Status byte layout
    localparam int PSW_Z = 6;
    localparam int PSW_SK = 5;
    localparam int PSW_HC = 4;
    localparam int PSW_L1 = 3;
    localparam int PSW_L0 = 2;
    localparam int PSW_CY = 0;
    // Register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam int CTRL_STACK_EN = 0;
    localparam int CTRL_WAKE = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    typedef enum logic [3:0] {
        SKCX_K_OTHER = 4'b0001,
        SKCX_K_SKIP = 4'b0010,
        SKCX_K_CTRL = 4'b0100,
        SKCX_K_PWR = 4'b1000
    } skcx_kind_t;

    typedef struct packed {
        logic valid;
        logic [7:0] op0;
        logic [7:0] op1;
        logic [1:0] len;
        logic [4:0] states;
        logic ldi_a;
        logic ldi_b;
        logic other_skip;
    } skcx_req_t;

    typedef struct packed {
        logic done;
        logic [1:0] pc_adv;
        logic skipped;
        logic suppressed;
    } skcx_rsp_t;

    typedef struct packed {
        skcx_kind_t kind;
        logic [1:0] len;
        logic [4:0] states;
    } skcx_dec_t;
endpackage : skcx_pkg

// ### verilog/skcx_unused.sv
`timescale 1ns/1ns
